// ### bench/protection_signal_routing_matrix_tb.sv
// self-checking bench of the routing matrix
`default_nettype none
module protection_signal_routing_matrix_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------
  // stimulus, outputs and the design
  // ---------------------------------------------------------------------
  localparam int ACYC = 20;
  localparam int SCYC = 10;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] st_i = 4'h0;
  logic [3:0] op_i = 4'h0;
  logic bc_i = 1'b0;
  logic rip_i = 1'b0;
  logic [7:0] rdata;
  logic [3:0] blk;
  logic ss1, ss2, ts1, ts2, ar1, ar2, ar3, mtrip, al1, al2, al3, inh, sset;
  int n_fail = 0;
  int num_checks = 0;

  // 50 MHz clock
  always #10 core_clk_i = ~core_clk_i;

  protection_signal_routing_matrix #(.ALARM_CYC(ACYC), .STEP_CYC(SCYC))
  i_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
    .stage_start_i(st_i), .stage_operate_i(op_i),
    .blocking_control_input_i(bc_i), .reclose_in_progress_i(rip_i),
    .start_line_first_o(ss1), .start_line_second_o(ss2),
    .trip_line_first_o(ts1), .trip_line_second_o(ts2),
    .reclose_start_first_o(ar1), .reclose_start_second_o(ar2),
    .reclose_start_third_o(ar3), .main_trip_o(mtrip),
    .alarm_out_first_o(al1), .alarm_out_second_o(al2),
    .alarm_out_third_o(al3), .reclose_inhibit_o(inh),
    .second_settings_o(sset), .stage_blocked_o(blk)
  );

  // ---------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // wait n edges, then 1 ns more
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    if (wr_i) tick(1);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    tick(1);
    wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    tick(1);
    rd_i <= 1'b0;
    chk("read data", rdata, e);
    tick(1);
  endtask

  // apply stage inputs, let sync settle
  task automatic drive(input logic [3:0] st, input logic [3:0] op,
                       input logic bc, input logic rp);
    st_i <= st;
    op_i <= op;
    bc_i <= bc;
    rip_i <= rp;
    tick(5);
  endtask

  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  task automatic t_regs();
    reg_rd(routing_pkg::OFS_BLOCK, 8'h00);
    reg_rd(routing_pkg::OFS_ROUTE_ONE, 8'hAB);
    reg_rd(routing_pkg::OFS_ROUTE_TWO, 8'hA5);
    reg_wr(routing_pkg::OFS_ROUTE_ONE, 8'h55);
    reg_rd(routing_pkg::OFS_ROUTE_ONE, 8'h55);
    reg_wr(routing_pkg::OFS_STATUS, 8'hFF);
    reg_rd(routing_pkg::OFS_STATUS, 8'h00);
    $display("regs done");
  endtask

  task automatic t_route(input logic [7:0] r1, input logic [7:0] r2);
    logic [4:0] e;
    reg_wr(routing_pkg::OFS_ROUTE_ONE, r1);
    reg_wr(routing_pkg::OFS_ROUTE_TWO, r2);
    for (int i = 0; i < 4; i++) begin
      drive(4'h1 << i, 4'h0, 1'b0, 1'b0);
      e = {2'b00, r1[2*i], r1[2*i], r1[2*i]};
      chk("start routing", {ss1, ar2, al3}, e);
      drive(4'h0, 4'h1 << i, 1'b0, 1'b0);
      e = {r1[2*i+1], r1[2*i+1], r2[2*i], r2[2*i+1], r2[2*i]};
      chk("operate routing", {ts2, mtrip, ss2, ar1, al3}, e);
    end
    drive(4'h0, 4'h0, 1'b0, 1'b0);
    $display("route done");
  endtask

  task automatic t_func();
    reg_wr(routing_pkg::OFS_FUNC_TWO, 8'hC0);
    drive(4'h2, 4'h0, 1'b0, 1'b0);
    chk("hs oc start reclose", ar1, 1'b1);
    drive(4'h4, 4'h0, 1'b0, 1'b0);
    chk("ls ef start reclose", ar3, 1'b1);
    drive(4'h8, 4'h0, 1'b0, 1'b0);
    chk("hs ef start reclose", ar3, 1'b1);
    reg_wr(routing_pkg::OFS_FUNC_TWO, 8'h00);
    drive(4'hE, 4'h0, 1'b0, 1'b0);
    chk("start reclose off", {ar1, ar3}, 2'b00);
    reg_wr(routing_pkg::OFS_OUT_ROUTE, 8'h26);
    drive(4'h1, 4'h0, 1'b0, 1'b0);
    chk("start one alarm off", {ss1, al3}, 2'b10);
    $display("func done");
  endtask

  task automatic t_block();
    for (int i = 0; i < 4; i++) begin
      reg_wr(routing_pkg::OFS_BLOCK, 8'h01 << i);
      drive(4'h0, 4'h1 << i, 1'b1, 1'b0);
      chk("blocked stage", {blk, ts2}, {4'h1 << i, 1'b0});
      drive(4'h0, 4'h1 << i, 1'b0, 1'b0);
      chk("unblocked stage", {blk, ts2}, 5'h01);
    end
    reg_wr(routing_pkg::OFS_BLOCK, 8'h10);
    drive(4'h0, 4'h0, 1'b1, 1'b0);
    chk("second settings", sset, 1'b1);
    drive(4'h0, 4'h0, 1'b0, 1'b0);
    chk("main settings", sset, 1'b0);
    $display("block done");
  endtask

  task automatic t_latch();
    for (int i = 0; i < 2; i++) begin
      reg_wr(routing_pkg::OFS_BLOCK, (i == 0) ? 8'hA0 : 8'hC0);
      drive(4'h0, (i == 0) ? 4'h1 : 4'h8, 1'b0, 1'b0);
      drive(4'h0, 4'h0, 1'b0, 1'b0);
      chk("latched trip", ts2, 1'b1);
      drive(4'h0, 4'h0, 1'b1, 1'b0);
      chk("remote reset", ts2, 1'b0);
    end
    reg_wr(routing_pkg::OFS_BLOCK, 8'h00);
    $display("latch done");
  endtask

  // ex: inhibit, main trip, alarm two, alarm one
  task automatic t_alarm(input logic [7:0] ov, input logic [3:0] op,
                         input logic [3:0] ex);
    reg_wr(routing_pkg::OFS_OUT_ROUTE, ov);
    drive(4'h0, op, 1'b0, 1'b0);
    tick(ACYC - 5);
    chk("alarm early", {inh, mtrip, al2, al1}, {ex[3:2], 2'b00});
    tick(5);
    chk("alarm late", {inh, mtrip, al2, al1}, ex);
    rip_i <= 1'b1;
    tick(4);
    chk("alarm in reclose", {al2, al1}, 2'b00);
    drive(4'h0, 4'h0, 1'b0, 1'b0);
    $display("alarm done");
  endtask

  task automatic t_delay();
    int n;
    reg_wr(routing_pkg::OFS_FUNC_ONE, 8'h08);
    reg_wr(routing_pkg::OFS_TRIP_DELAY, 8'h02);
    drive(4'h0, 4'h1, 1'b0, 1'b0);
    tick(2 * SCYC - 5);
    chk("delay early", ts1, 1'b0);
    n = 0;
    while (ts1 !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk("delay late", ts1, 1'b1);
    if (n == 20) conclude();
    drive(4'h0, 4'h0, 1'b0, 1'b0);
    chk("delay off", ts1, 1'b0);
    $display("delay done");
  endtask

  // reset ten cycles, then every scenario
  initial begin
    tick(10);
    rst_n_i <= 1'b1;
    tick(3);
    t_regs();
    t_route(8'hAB, 8'hA5);
    t_route(8'h54, 8'h5A);
    t_route(8'hAB, 8'hA5);
    t_func();
    t_block();
    t_latch();
    t_alarm(8'h27, 4'h1, 4'h5);
    t_alarm(8'hA5, 4'h1, 4'h6);
    t_alarm(8'h23, 4'h4, 4'hA);
    t_delay();
    conclude();
  end
endmodule
`default_nettype wire

// ### bench/routing_matrix_asserts.sv
// concurrent checks on the routing matrix ports
`default_nettype none
module routing_matrix_asserts #(
  parameter int ALARM_CYC = 20,
  parameter int STEP_CYC = 10
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic reclose_in_progress_i,
  input wire logic trip_line_first_o,
  input wire logic trip_line_second_o,
  input wire logic start_line_second_o,
  input wire logic main_trip_o,
  input wire logic alarm_out_first_o,
  input wire logic alarm_out_second_o,
  input wire logic alarm_out_third_o,
  input wire logic reclose_inhibit_o,
  input wire logic second_settings_o,
  input wire logic [3:0] stage_blocked_o
);
  // ---------------------------------------------------------------------
  // selector shadows and run lengths
  // ---------------------------------------------------------------------
  logic [7:0] f1_q, blk_q, out_q;
  logic [31:0] mt_cnt, ts2_cnt;

  // shadows follow writes, counters measure trip runs
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      f1_q <= routing_pkg::FUNC_ONE_RST;
      blk_q <= routing_pkg::BLOCK_RST;
      out_q <= routing_pkg::OUT_ROUTE_RST;
      mt_cnt <= 32'h0;
      ts2_cnt <= 32'h0;
    end else begin
      if (wr_i && addr_i == routing_pkg::OFS_FUNC_ONE) f1_q <= wdata_i;
      if (wr_i && addr_i == routing_pkg::OFS_BLOCK) blk_q <= wdata_i;
      if (wr_i && addr_i == routing_pkg::OFS_OUT_ROUTE) out_q <= wdata_i;
      mt_cnt <= main_trip_o ? mt_cnt + 32'h1 : 32'h0;
      ts2_cnt <= trip_line_second_o ? ts2_cnt + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // write then read of the same register
  sequence s_wr_rd;
    wr_i && addr_i <= routing_pkg::OFS_ROUTE_TWO ##1
      rd_i && addr_i == $past(addr_i);
  endsequence

  reset_quiet_a: assert property ($rose(rst_n_i) |->
    !main_trip_o && !trip_line_second_o && rdata_o == 8'h00)
    else $error("active after reset");
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero");
  write_read_a: assert property (s_wr_rd |=>
    rdata_o == $past(wdata_i, 2)) else $error("readback differs");
  main_trip_a: assert property (
    trip_line_first_o || trip_line_second_o |-> main_trip_o)
    else $error("trip without main trip");
  third_alarm_a: assert property (
    start_line_second_o |-> alarm_out_third_o)
    else $error("start two not on third alarm");
  alarm_hold_a: assert property (reclose_in_progress_i[*4] |->
    !alarm_out_first_o && !alarm_out_second_o)
    else $error("alarm during reclose");
  alarm_delay_a: assert property ($rose(alarm_out_first_o) |->
    mt_cnt >= ALARM_CYC - 2) else $error("first alarm too early");
  delay_trip_a: assert property ($rose(trip_line_first_o) |->
    f1_q[3] && ts2_cnt >= STEP_CYC - 2)
    else $error("delayed trip early");
  inhibit_sel_a: assert property (
    $rose(reclose_inhibit_o) |-> !out_q[2])
    else $error("inhibit while trip routed");
  second_set_a: assert property (
    second_settings_o |-> blk_q[4] || $past(blk_q[4]))
    else $error("second set not enabled");
  blocked_sel_a: assert property (
    (stage_blocked_o & ~(blk_q[3:0] | $past(blk_q[3:0]))) == 4'h0)
    else $error("blocked without its bit");
endmodule

bind protection_signal_routing_matrix routing_matrix_asserts #(
  .ALARM_CYC(ALARM_CYC),
  .STEP_CYC(STEP_CYC)
) i_asserts (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .reclose_in_progress_i(reclose_in_progress_i),
  .trip_line_first_o(trip_line_first_o),
  .trip_line_second_o(trip_line_second_o),
  .start_line_second_o(start_line_second_o), .main_trip_o(main_trip_o),
  .alarm_out_first_o(alarm_out_first_o),
  .alarm_out_second_o(alarm_out_second_o),
  .alarm_out_third_o(alarm_out_third_o),
  .reclose_inhibit_o(reclose_inhibit_o),
  .second_settings_o(second_settings_o),
  .stage_blocked_o(stage_blocked_o)
);
`default_nettype wire

// ### common/routing_pkg.sv
// constants, register map and types shared by the protection routing matrix
`default_nettype none
package routing_pkg;
  // -------------------------------------------------------------------------
  // register port geometry and offsets
  // -------------------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] OFS_FUNC_ONE = 3'h0;
  localparam logic [2:0] OFS_FUNC_TWO = 3'h1;
  localparam logic [2:0] OFS_BLOCK = 3'h2;
  localparam logic [2:0] OFS_ROUTE_ONE = 3'h3;
  localparam logic [2:0] OFS_ROUTE_TWO = 3'h4;
  localparam logic [2:0] OFS_OUT_ROUTE = 3'h5;
  localparam logic [2:0] OFS_TRIP_DELAY = 3'h6;
  localparam logic [2:0] OFS_STATUS = 3'h7;
  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0] FUNC_ONE_RST = 8'h00;
  localparam logic [7:0] FUNC_TWO_RST = 8'h00;
  localparam logic [7:0] BLOCK_RST = 8'h00;
  localparam logic [7:0] ROUTE_ONE_RST = 8'hAB;
  localparam logic [7:0] ROUTE_TWO_RST = 8'hA5;
  localparam logic [7:0] OUT_ROUTE_RST = 8'h27;
  localparam logic [7:0] TRIP_DELAY_RST = 8'h01;
  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int F1_DELAYED_TRIP_BIT = 3;
  localparam int F2_HS_OC_AR1_BIT = 6;
  localparam int F2_EF_AR3_BIT = 7;
  localparam int BLK_SECOND_SET_BIT = 4;
  localparam int BLK_LATCH_OC_BIT = 5;
  localparam int BLK_LATCH_EF_BIT = 6;
  localparam int BLK_REMOTE_RESET_BIT = 7;
  localparam int OUT_SS1_SIG3_BIT = 0;
  localparam int OUT_TRIP_SIG1_BIT = 1;
  localparam int OUT_LSEF_TRIP_BIT = 2;
  localparam int OUT_ANY_SIG1_BIT = 6;
  localparam int OUT_ANY_SIG2_BIT = 7;
  // stage indices: 0 low-set oc, 1 high-set oc, 2 low-set ef, 3 high-set ef
  localparam int STAGES = 4;
  localparam int STG_HS_OC = 1;
  localparam int STG_LS_EF = 2;
  localparam int STG_HS_EF = 3;
  localparam int SYNC_W = 10;
  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int CLK_KHZ = 50_000;
  localparam int ALARM_DELAY_MS = 40;
  localparam int ALARM_DELAY_CYC = ALARM_DELAY_MS * CLK_KHZ;
  localparam int TRIP_STEP_MS = 100;
  localparam int TRIP_STEP_CYC = TRIP_STEP_MS * CLK_KHZ;
  localparam logic [7:0] TRIP_STEPS_MIN = 8'h01;
  localparam logic [7:0] TRIP_STEPS_MAX = 8'h0A;
  // delayed trip timer states, gray along idle -> run -> trip
  typedef enum logic [1:0] {
    DT_IDLE = 2'b00,
    DT_RUN = 2'b01,
    DT_TRIP = 2'b11
  } dt_state_e;
endpackage
`default_nettype wire

// ### src/protection_signal_routing_matrix.sv
// start, trip and reclose routing matrix of the feeder protection terminal
// Function
// - selector bit 2 zero: low-set ef trip only signals, inhibits reclose
// - out selector bit 7: second alarm output becomes general trip alarm
// - first and second alarm outputs activate only after 40 ms
// - reclose in progress inhibits first and second alarm outputs
// - weight 8 in function group one: second trip delays into first
// - weight 64 in function group two: high-set oc start to reclose one
// - weight 128 in function group two: ef starts to reclose three
// - blocking weights 1,2,4,8 let control input block each stage
// - blocking weight 16 selects second settings by control input
// - blocking weights 32, 64 latch oc and ef second trip line
// - blocking weight 128 lets control input reset latched outputs
// - blocking group resets to all zero, checksum 0
// - routing one even bits route starts to start one, reclose two
// - routing one odd bits route operates to second trip line
// - routing one resets to checksum 171
// - routing two even bits route operates to start line two
// - routing two odd bits route operates to reclose start one
// - routing two resets to checksum 165
// - both trip lines drive main trip, first alarm through its selector
// - start two drives third alarm, start one only through selector
//
// The implementer's own choices: the strobed register port and the register offsets.
`default_nettype none
module protection_signal_routing_matrix #(
  parameter int ALARM_CYC = routing_pkg::ALARM_DELAY_CYC,
  parameter int STEP_CYC = routing_pkg::TRIP_STEP_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [routing_pkg::ADDR_W-1:0] addr_i,
  input wire logic [routing_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [routing_pkg::DATA_W-1:0] rdata_o,
  input wire logic [routing_pkg::STAGES-1:0] stage_start_i,
  input wire logic [routing_pkg::STAGES-1:0] stage_operate_i,
  input wire logic blocking_control_input_i,
  input wire logic reclose_in_progress_i,
  output logic start_line_first_o,
  output logic start_line_second_o,
  output logic trip_line_first_o,
  output logic trip_line_second_o,
  output logic reclose_start_first_o,
  output logic reclose_start_second_o,
  output logic reclose_start_third_o,
  output logic main_trip_o,
  output logic alarm_out_first_o,
  output logic alarm_out_second_o,
  output logic alarm_out_third_o,
  output logic reclose_inhibit_o,
  output logic second_settings_o,
  output logic [routing_pkg::STAGES-1:0] stage_blocked_o
);
  localparam int AW = $clog2(ALARM_CYC + 1);
  localparam int SW = $clog2(STEP_CYC + 1);
  localparam logic [AW-1:0] ALARM_LIM = AW'(ALARM_CYC);
  localparam logic [SW-1:0] STEP_LIM = SW'(STEP_CYC - 1);

  // -------------------------------------------------------------------------
  // register file
  // -------------------------------------------------------------------------
  logic [7:0] function_select_one_reg;
  logic [7:0] function_select_two_reg;
  logic [7:0] blocking_control_select_reg;
  logic [7:0] start_trip_routing_one_reg;
  logic [7:0] start_reclose_routing_two_reg;
  logic [7:0] output_routing_selectors_reg;
  logic [7:0] trip_delay_steps_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] status_word;

  // write decode, one strobe per register
  wire we_f1 = wr_i && (addr_i == routing_pkg::OFS_FUNC_ONE);
  wire we_f2 = wr_i && (addr_i == routing_pkg::OFS_FUNC_TWO);
  wire we_blk = wr_i && (addr_i == routing_pkg::OFS_BLOCK);
  wire we_r1 = wr_i && (addr_i == routing_pkg::OFS_ROUTE_ONE);
  wire we_r2 = wr_i && (addr_i == routing_pkg::OFS_ROUTE_TWO);
  wire we_out = wr_i && (addr_i == routing_pkg::OFS_OUT_ROUTE);
  wire we_dly = wr_i && (addr_i == routing_pkg::OFS_TRIP_DELAY);

  // groups hold the weighted sum of set bits
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      function_select_one_reg <= routing_pkg::FUNC_ONE_RST;
      function_select_two_reg <= routing_pkg::FUNC_TWO_RST;
      blocking_control_select_reg <= routing_pkg::BLOCK_RST;
      start_trip_routing_one_reg <= routing_pkg::ROUTE_ONE_RST;
      start_reclose_routing_two_reg <= routing_pkg::ROUTE_TWO_RST;
      output_routing_selectors_reg <= routing_pkg::OUT_ROUTE_RST;
      trip_delay_steps_reg <= routing_pkg::TRIP_DELAY_RST;
    end else begin
      if (we_f1) begin
        function_select_one_reg <= wdata_i;
      end
      if (we_f2) begin
        function_select_two_reg <= wdata_i;
      end
      if (we_blk) begin
        blocking_control_select_reg <= wdata_i;
      end
      if (we_r1) begin
        start_trip_routing_one_reg <= wdata_i;
      end
      if (we_r2) begin
        start_reclose_routing_two_reg <= wdata_i;
      end
      if (we_out) begin
        output_routing_selectors_reg <= wdata_i;
      end
      if (we_dly) begin
        trip_delay_steps_reg <= wdata_i;
      end
    end
  end

  // read mux, data valid in the cycle after the strobe only
  always_comb begin
    rdata_next = 8'h00;
    if (rd_i) begin
      case (addr_i)
        routing_pkg::OFS_FUNC_ONE: rdata_next = function_select_one_reg;
        routing_pkg::OFS_FUNC_TWO: rdata_next = function_select_two_reg;
        routing_pkg::OFS_BLOCK: rdata_next = blocking_control_select_reg;
        routing_pkg::OFS_ROUTE_ONE: rdata_next = start_trip_routing_one_reg;
        routing_pkg::OFS_ROUTE_TWO: rdata_next = start_reclose_routing_two_reg;
        routing_pkg::OFS_OUT_ROUTE: rdata_next = output_routing_selectors_reg;
        routing_pkg::OFS_TRIP_DELAY: rdata_next = trip_delay_steps_reg;
        routing_pkg::OFS_STATUS: rdata_next = status_word;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign rdata_o = rdata_reg;

  // -------------------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------------------
  logic [routing_pkg::SYNC_W-1:0] sync_a_reg;
  logic [routing_pkg::SYNC_W-1:0] sync_b_reg;

  // two flops on every external level
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sync_a_reg <= '0;
      sync_b_reg <= '0;
    end else begin
      sync_a_reg <= {reclose_in_progress_i, blocking_control_input_i,
                     stage_operate_i, stage_start_i};
      sync_b_reg <= sync_a_reg;
    end
  end

  wire [3:0] start_s = sync_b_reg[3:0];
  wire [3:0] operate_s = sync_b_reg[7:4];
  wire control_s = sync_b_reg[8];
  wire reclose_busy_s = sync_b_reg[9];

  // -------------------------------------------------------------------------
  // blocking, settings switch and per-stage routing
  // -------------------------------------------------------------------------
  wire [3:0] blocked = blocking_control_select_reg[3:0] & {4{control_s}};
  wire [3:0] operate_eff = operate_s & ~blocked;
  wire second_set =
    blocking_control_select_reg[routing_pkg::BLK_SECOND_SET_BIT] &
    control_s;
  wire remote_reset =
    blocking_control_select_reg[routing_pkg::BLK_REMOTE_RESET_BIT] &
    control_s;
  wire lsef_to_trip =
    output_routing_selectors_reg[routing_pkg::OUT_LSEF_TRIP_BIT];
  // low-set ef trip only signals
  wire lsef_signal = operate_eff[routing_pkg::STG_LS_EF] & ~lsef_to_trip;

  logic [3:0] to_start_one;
  logic [3:0] to_trip_two;
  logic [3:0] to_start_two;
  logic [3:0] to_reclose_one;

  // per stage: even bit start or operate, odd bit operate
  for (genvar s = 0; s < routing_pkg::STAGES; s++) begin : g_stage
    wire trip_allow = (s == routing_pkg::STG_LS_EF) ? lsef_to_trip : 1'b1;
    assign to_start_one[s] =
      start_trip_routing_one_reg[2*s] & start_s[s];
    assign to_trip_two[s] =
      start_trip_routing_one_reg[2*s+1] & operate_eff[s] & trip_allow;
    assign to_start_two[s] =
      start_reclose_routing_two_reg[2*s] & operate_eff[s];
    assign to_reclose_one[s] =
      start_reclose_routing_two_reg[2*s+1] & operate_eff[s];
  end

  wire ss1 = |to_start_one;
  wire ss2 = |to_start_two;
  wire ar1 = (|to_reclose_one) |
    (function_select_two_reg[routing_pkg::F2_HS_OC_AR1_BIT] &
     start_s[routing_pkg::STG_HS_OC]);
  wire ar2 = ss1;
  wire ar3 = function_select_two_reg[routing_pkg::F2_EF_AR3_BIT] &
    (start_s[routing_pkg::STG_LS_EF] | start_s[routing_pkg::STG_HS_EF]);

  // -------------------------------------------------------------------------
  // second trip line latching
  // -------------------------------------------------------------------------
  logic latch_oc_reg;
  logic latch_ef_reg;
  wire oc_raw = to_trip_two[0] | to_trip_two[1];
  wire ef_raw = to_trip_two[2] | to_trip_two[3];
  wire latch_oc_en = blocking_control_select_reg[routing_pkg::BLK_LATCH_OC_BIT];
  wire latch_ef_en = blocking_control_select_reg[routing_pkg::BLK_LATCH_EF_BIT];
  // a new trip wins over a remote reset
  wire latch_oc_next = latch_oc_en &
    (oc_raw | (latch_oc_reg & ~remote_reset));
  wire latch_ef_next = latch_ef_en &
    (ef_raw | (latch_ef_reg & ~remote_reset));

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      latch_oc_reg <= 1'b0;
      latch_ef_reg <= 1'b0;
    end else begin
      latch_oc_reg <= latch_oc_next;
      latch_ef_reg <= latch_ef_next;
    end
  end

  wire ts2 = oc_raw | ef_raw | latch_oc_reg | latch_ef_reg;

  // -------------------------------------------------------------------------
  // delayed trip timer: trip two drives trip one late
  // -------------------------------------------------------------------------
  routing_pkg::dt_state_e dt_state_reg;
  routing_pkg::dt_state_e dt_state_next;
  logic [SW-1:0] step_cnt_reg;
  logic [SW-1:0] step_cnt_next;
  logic [7:0] steps_reg;
  logic [7:0] steps_next;
  wire dt_enable =
    function_select_one_reg[routing_pkg::F1_DELAYED_TRIP_BIT];
  // delay setting clamped to 1..10 steps of 100 ms
  wire [7:0] steps_target =
    (trip_delay_steps_reg < routing_pkg::TRIP_STEPS_MIN) ?
    routing_pkg::TRIP_STEPS_MIN :
    (trip_delay_steps_reg > routing_pkg::TRIP_STEPS_MAX) ?
    routing_pkg::TRIP_STEPS_MAX : trip_delay_steps_reg;
  wire step_done = (step_cnt_reg == STEP_LIM);

  // timer runs while trip two stands
  always_comb begin
    dt_state_next = dt_state_reg;
    step_cnt_next = '0;
    steps_next = 8'h00;
    case (dt_state_reg)
      routing_pkg::DT_IDLE: begin
        if (dt_enable && ts2) begin
          dt_state_next = routing_pkg::DT_RUN;
        end
      end
      routing_pkg::DT_RUN: begin
        if (!(dt_enable && ts2)) begin
          dt_state_next = routing_pkg::DT_IDLE;
        end else if (step_done) begin
          steps_next = steps_reg + 8'h01;
          if (steps_next == steps_target) begin
            dt_state_next = routing_pkg::DT_TRIP;
          end
        end else begin
          step_cnt_next = step_cnt_reg + 1'b1;
          steps_next = steps_reg;
        end
      end
      routing_pkg::DT_TRIP: begin
        if (!(dt_enable && ts2)) begin
          dt_state_next = routing_pkg::DT_IDLE;
        end
      end
      default: dt_state_next = routing_pkg::DT_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dt_state_reg <= routing_pkg::DT_IDLE;
      step_cnt_reg <= '0;
      steps_reg <= 8'h00;
    end else begin
      dt_state_reg <= dt_state_next;
      step_cnt_reg <= step_cnt_next;
      steps_reg <= steps_next;
    end
  end

  wire ts1 = (dt_state_next == routing_pkg::DT_TRIP);
  wire main_trip = ts1 | ts2;

  // -------------------------------------------------------------------------
  // signalling outputs: 40 ms on-delay and reclose inhibit on first and second, third undelayed
  // -------------------------------------------------------------------------
  wire [1:0] alarm_raw;
  wire [1:0] alarm_on;
  assign alarm_raw[0] =
    (output_routing_selectors_reg[routing_pkg::OUT_TRIP_SIG1_BIT] &
     (ts1 | ts2)) |
    (output_routing_selectors_reg[routing_pkg::OUT_ANY_SIG1_BIT] & main_trip);
  assign alarm_raw[1] = lsef_signal |
    (output_routing_selectors_reg[routing_pkg::OUT_ANY_SIG2_BIT] &
     main_trip);

  // on-delay per alarm, cleared during reclose
  for (genvar a = 0; a < 2; a++) begin : g_alarm
    logic [AW-1:0] cnt_reg;
    logic [AW-1:0] cnt_next;
    wire run = alarm_raw[a] & ~reclose_busy_s;
    assign cnt_next = !run ? '0 :
      (cnt_reg == ALARM_LIM) ? cnt_reg : cnt_reg + 1'b1;
    assign alarm_on[a] = (cnt_next == ALARM_LIM);
    always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_next;
      end
    end
  end

  wire alarm_third = ss2 |
    (output_routing_selectors_reg[routing_pkg::OUT_SS1_SIG3_BIT] & ss1);

  // status word: live line state for software
  assign status_word = {second_set, latch_ef_reg, latch_oc_reg, ts1, ts2,
                        ss2, ss1, main_trip};

  // -------------------------------------------------------------------------
  // output registers
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      start_line_first_o <= 1'b0;
      start_line_second_o <= 1'b0;
      trip_line_first_o <= 1'b0;
      trip_line_second_o <= 1'b0;
      reclose_start_first_o <= 1'b0;
      reclose_start_second_o <= 1'b0;
      reclose_start_third_o <= 1'b0;
      main_trip_o <= 1'b0;
      alarm_out_first_o <= 1'b0;
      alarm_out_second_o <= 1'b0;
      alarm_out_third_o <= 1'b0;
      reclose_inhibit_o <= 1'b0;
      second_settings_o <= 1'b0;
      stage_blocked_o <= '0;
    end else begin
      start_line_first_o <= ss1;
      start_line_second_o <= ss2;
      trip_line_first_o <= ts1;
      trip_line_second_o <= ts2;
      reclose_start_first_o <= ar1;
      reclose_start_second_o <= ar2;
      reclose_start_third_o <= ar3;
      main_trip_o <= main_trip;
      alarm_out_first_o <= alarm_on[0];
      alarm_out_second_o <= alarm_on[1];
      alarm_out_third_o <= alarm_third;
      reclose_inhibit_o <= lsef_signal;
      second_settings_o <= second_set;
      stage_blocked_o <= blocked;
    end
  end
endmodule
`default_nettype wire
